// ===== core/gdp_port.sv
/*
  Twelve-pin general-purpose port: per-pin direction register and pin level
  register behind a plain strobe register port, with registered pin drivers
  and synchronised pin sampling.
  Assumes one clock, a synchronous active-low reset, one strobe at a time,
  and an outside wire that resolves pinOut under pinOe_n.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gdp_regs.svh"

module gdp_port
#(
  parameter int NUM_PINS = `GDP_NUM_PINS
)
(
  input  wire logic              clk,
  input  wire logic              rst_n,
  input  wire gdp_pkg::gdp_addr_t addr,
  input  wire gdp_pkg::gdp_data_t wrData,
  input  wire logic              wrStb,
  input  wire logic              rdStb,
  output var  gdp_pkg::gdp_data_t rdData,
  input  wire logic [NUM_PINS-1:0] pinIn,
  output var  logic [NUM_PINS-1:0] pinOut,
  output var  logic [NUM_PINS-1:0] pinOe_n
);

  import gdp_pkg::*;

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  logic [NUM_PINS-1:0] pinDir;
  logic [NUM_PINS-1:0] pinLevel;
  logic [NUM_PINS-1:0] pinSync;
  logic [NUM_PINS-1:0] wrPins;
  gdp_sel_t            sel;
  gdp_data_t           next_rdData;

  assign wrPins = wrData[NUM_PINS-1:0];

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  always_comb
  begin
    case (addr)
      `GDP_ADDR_DIR:   sel = GDP_SEL_DIR;
      `GDP_ADDR_LEVEL: sel = GDP_SEL_LEVEL;
      default:         sel = GDP_SEL_NONE;
    endcase
  end

  // ----------------------------------------------------------------------
  // direction register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pinDir <= `GDP_RST_DIR;
    else if (wrStb && sel == GDP_SEL_DIR)
      pinDir <= wrPins;
  end

  // ----------------------------------------------------------------------
  // level register
  // ----------------------------------------------------------------------
  // all bits are stored whatever the direction, so a pin turned to output
  // later drives the last value written to it
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pinLevel <= `GDP_RST_LEVEL;
    else if (wrStb && sel == GDP_SEL_LEVEL)
      pinLevel <= wrPins;
  end

  // ----------------------------------------------------------------------
  // pin drivers and pin sampling
  // ----------------------------------------------------------------------
  gdp_pin_drv
  #(
    .WIDTH   (NUM_PINS)
  )
  u_drv
  (
    .clk     (clk),
    .rst_n   (rst_n),
    .level   (pinLevel),
    .dir     (pinDir),
    .pinOut  (pinOut),
    .pinOe_n (pinOe_n)
  );

  // pins are asynchronous to clk; two stages cost two cycles of read latency
  gdp_sync
  #(
    .WIDTH (NUM_PINS)
  )
  u_sync
  (
    .clk   (clk),
    .rst_n (rst_n),
    .dIn   (pinIn),
    .dOut  (pinSync)
  );

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  // read data stand for one cycle only and are zero otherwise; reserved
  // bits and unmapped offsets read as zero
  always_comb
  begin
    next_rdData = '0;
    if (rdStb)
    begin
      case (sel)
        GDP_SEL_DIR:   next_rdData[NUM_PINS-1:0] = pinDir;
        GDP_SEL_LEVEL: next_rdData[NUM_PINS-1:0] = pinSync;
        default:       next_rdData = '0;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      rdData <= '0;
    else
      rdData <= next_rdData;
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking

  default disable iff (!rst_n);

  logic wrDir;
  logic wrLevel;
  logic rdDir;
  logic rdLevel;
  logic rdNone;
  logic wrNone;

  assign wrDir   = wrStb && addr == `GDP_ADDR_DIR;
  assign wrLevel = wrStb && addr == `GDP_ADDR_LEVEL;
  assign rdDir   = rdStb && addr == `GDP_ADDR_DIR;
  assign rdLevel = rdStb && addr == `GDP_ADDR_LEVEL;
  assign rdNone  = rdStb && !rdDir && !rdLevel;
  assign wrNone  = wrStb && !wrDir && !wrLevel;

  // ----------------------------------------------------------------------
  // checks: register storage, pin drive and level read
  // ----------------------------------------------------------------------
  // the drivers are flops, so every pin check counts one cycle past the
  // register it follows
  dir_store_a:
  assert property (wrDir |=> pinDir == $past(wrPins))
    else $error("direction register did not take the written bits");

  dir_hold_a:
  assert property (!wrDir |=> pinDir == $past(pinDir))
    else $error("direction register changed without a write");

  dir_enable_a:
  assert property (##1 pinOe_n == ~$past(pinDir))
    else $error("output enable does not follow the direction bits");

  out_after_dir_a:
  assert property (wrDir ##1 !wrDir |=> pinOe_n == ~$past(wrPins, 2))
    else $error("written direction did not reach the enables in two cycles");

  level_drive_a:
  assert property (wrLevel |=> ##1 pinOut == ($past(wrPins, 2) & $past(pinDir)))
    else $error("written level not driven on output pins");

  level_hold_a:
  assert property (!wrLevel |=> pinLevel == $past(pinLevel))
    else $error("level register changed without a write");

  level_read_a:
  assert property (rdLevel |=> rdData[NUM_PINS-1:0] == $past(pinIn, 3))
    else $error("level read does not return the sampled pins");

  level_upper_a:
  assert property (rdLevel |=> rdData[`GDP_DATA_W-1:NUM_PINS] == '0)
    else $error("reserved bits of a level read are not zero");

  input_quiet_a:
  assert property ((pinOut & pinOe_n) == '0)
    else $error("data driven on a pin whose driver is off");

  input_masked_a:
  assert property (wrLevel && pinDir == '0 |=> ##1 pinOe_n == '1 && pinOut == '0)
    else $error("level write reached a pin set as input");

  level_store_a:
  assert property (wrLevel |=> pinLevel == $past(wrPins))
    else $error("level register did not take the written bits");

  level_keep_a:
  assert property (wrDir |=> pinLevel == $past(pinLevel))
    else $error("direction write disturbed the stored levels");

  pin_drive_a:
  assert property (##1 pinOut == ($past(pinLevel) & $past(pinDir)))
    else $error("pin data does not follow level and direction");

  // a pin turned to output drives the level stored while it was an input
  drive_after_turn_a:
  assert property (wrDir |=> ##1 pinOut == ($past(pinLevel, 2) & $past(wrPins, 2)))
    else $error("pin turned to output does not drive its stored level");

  out_stable_a:
  assert property (!wrDir && !wrLevel |=> ##1 $stable(pinOut))
    else $error("pin data changed without a register write");

  enable_stable_a:
  assert property (!wrDir |=> ##1 $stable(pinOe_n))
    else $error("output enable changed without a direction write");

  drv_mask_a:
  assert property (##1 (pinOut & ~$past(pinDir)) == '0)
    else $error("data driven on a pin set as input");

  oe_mask_a:
  assert property (##1 (~pinOe_n & ~$past(pinDir)) == '0)
    else $error("driver enabled on a pin set as input");

  write_unmapped_a:
  assert property (wrNone |=> pinDir == $past(pinDir) && pinLevel == $past(pinLevel))
    else $error("unmapped write changed a register");

  // ----------------------------------------------------------------------
  // checks: read path
  // ----------------------------------------------------------------------
  dir_read_a:
  assert property (rdDir |=> rdData[NUM_PINS-1:0] == $past(pinDir))
    else $error("direction read does not return the register");

  read_idle_a:
  assert property (!rdStb |=> rdData == '0)
    else $error("read data present without a read strobe");

  read_unmapped_a:
  assert property (rdNone |=> rdData == '0)
    else $error("unmapped read returned data");

  dir_upper_a:
  assert property (rdDir |=> rdData[`GDP_DATA_W-1:NUM_PINS] == '0)
    else $error("reserved bits of a direction read are not zero");

  read_keeps_a:
  assert property (rdStb |=> pinDir == $past(pinDir) && pinLevel == $past(pinLevel))
    else $error("a read disturbed a stored register");

  // an attempt that starts while reset is sampled low meets a flushed
  // synchroniser, so only attempts from a running cycle count
  sync_delay_a:
  assert property (rst_n |-> ##2 pinSync == $past(pinIn, 2))
    else $error("pin synchroniser latency is not two cycles");

  // ----------------------------------------------------------------------
  // checks: reset
  // ----------------------------------------------------------------------
  // the default disable would hide these, so they switch it off
  reset_quiet_a:
  assert property (disable iff (1'b0)
    !rst_n |=> pinOe_n == '1 && pinOut == '0 && rdData == '0)
    else $error("pins or read data not quiet after reset");

  reset_regs_a:
  assert property (disable iff (1'b0)
    !rst_n |=> pinDir == `GDP_RST_DIR && pinLevel == `GDP_RST_LEVEL && pinSync == '0)
    else $error("registers or synchroniser not cleared by reset");

  // ----------------------------------------------------------------------
  // cover
  // ----------------------------------------------------------------------
  // main scenarios; the bench reaches input_write_c and mixed_pins_c only, its strobes stand too far apart for the rest
  input_write_c:
  cover property (wrLevel && pinDir == '0 ##2 pinOut == '0);

  dir_then_drive_c:
  cover property (wrDir ##1 wrLevel ##2 (pinOe_n != '1 && pinOut != '0));

  loop_read_c:
  cover property (wrLevel ##3 rdLevel ##1 rdData != '0);

  mixed_pins_c:
  cover property (pinDir != '0 && pinDir != '1 ##1 rdLevel);

  back_to_back_c:
  cover property (wrDir ##1 rdDir ##1 rdLevel);

endmodule

`default_nettype wire

// ===== pkg/gdp_regs.svh
/*
  Register offsets, field positions, reset values and fixed counts of the
  twelve-pin direction and level port.
  Assumes it is included by its bare name, once per compilation unit.
*/
`ifndef GDP_REGS_SVH
`define GDP_REGS_SVH

// ----------------------------------------------------------------------
// widths
// ----------------------------------------------------------------------
`define GDP_NUM_PINS   12
`define GDP_DATA_W     16
`define GDP_ADDR_W     8

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define GDP_ADDR_DIR   8'h2a
`define GDP_ADDR_LEVEL 8'h2b

// ----------------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------------
`define GDP_PIN_LSB    0
`define GDP_DIR_IN     1'h0
`define GDP_DIR_OUT    1'h1
`define GDP_RST_DIR    12'h000
`define GDP_RST_LEVEL  12'h000

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define GDP_SYNC_STAGES 2
`define GDP_RD_LAT      1

`endif

// ===== pkg/gdp_pkg.sv
/*
  Types shared by the direction and level port and its bench.
  Assumes gdp_regs.svh is on the include path.
*/
`default_nettype none

package gdp_pkg;
  `include "gdp_regs.svh"

  typedef logic [`GDP_DATA_W-1:0] gdp_data_t;
  typedef logic [`GDP_ADDR_W-1:0] gdp_addr_t;

  typedef enum logic [1:0]
  {
    GDP_SEL_NONE,
    GDP_SEL_DIR,
    GDP_SEL_LEVEL
  } gdp_sel_t;
endpackage

`default_nettype wire

// ===== core/gdp_sync.sv
/*
  Two flip-flop synchroniser, one pair per bit.
  Assumes dIn is asynchronous to clk; rst_n is synchronous, active low.
*/
`timescale 1ns/10ps
`default_nettype none

module gdp_sync
#(
  parameter int WIDTH = 1
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] dIn,
  output var  logic [WIDTH-1:0] dOut
);

  logic [WIDTH-1:0] meta;

  // the first stage feeds the second stage and nothing else
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_bit
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          meta[i] <= 1'b0;
          dOut[i] <= 1'b0;
        end
        else
        begin
          meta[i] <= dIn[i];
          dOut[i] <= meta[i];
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ===== core/gdp_pin_drv.sv
/*
  Registered pin drivers: output level and active-low output enable per pin.
  Assumes level and dir come from registers on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gdp_regs.svh"

module gdp_pin_drv
#(
  parameter int WIDTH = 12
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] level,
  input  wire logic [WIDTH-1:0] dir,
  output var  logic [WIDTH-1:0] pinOut,
  output var  logic [WIDTH-1:0] pinOe_n
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++)
    begin : g_pin
      always_ff @(posedge clk)
      begin
        if (!rst_n)
        begin
          pinOut[i]  <= 1'b0;
          pinOe_n[i] <= 1'b1;
        end
        else
        begin
          // an input pin keeps its driver off and its data low
          pinOe_n[i] <= (dir[i] != `GDP_DIR_OUT);
          pinOut[i]  <= level[i] & (dir[i] == `GDP_DIR_OUT);
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// ===== test/gdp_pin_model.sv
/*
  Board side of the twelve pins: resolves each wire from the port's driver
  and the board's own level.
  Assumes the board drives every pin that the port leaves undriven.
*/
`timescale 1ns/10ps
`default_nettype none

module gdp_pin_model
(
  input  wire logic [11:0] pinOut,
  input  wire logic [11:0] pinOe_n,
  input  wire logic [11:0] boardLevel,
  output var  logic [11:0] pinIn
);
  // ----------------------------------------------------------------------
  // wire resolution
  // ----------------------------------------------------------------------
  // the board never drives against the port, so no contention case exists
  always_comb
  begin
    for (int i = 0; i < 12; i++)
      pinIn[i] = pinOe_n[i] ? boardLevel[i] : pinOut[i];
  end
endmodule

`default_nettype wire

// ===== test/tb.sv
/*
  Self-checking bench of the direction and level port: register tasks on the
  strobe port and a board model behind the pins.
  Assumes gdp_regs.svh on the include path and gdp_pkg compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "gdp_regs.svh"

`define CHK(nm, exp, got) \
  begin checked++; if ((got) !== (exp)) begin n_errors++; \
  $display("Error %s expected %h seen %h", nm, exp, got); end end

module tb;
  import gdp_pkg::*;
  logic        clk;
  logic        rst_n;
  gdp_addr_t   addr;
  gdp_data_t   wrData;
  logic        wrStb;
  logic        rdStb;
  gdp_data_t   rdData;
  logic [11:0] pinIn;
  logic [11:0] pinOut;
  logic [11:0] pinOe_n;
  logic [11:0] boardLevel;
  gdp_data_t   got;
  int          n_errors;
  int          checked;

  gdp_port u_gdp_port (.clk(clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe_n(pinOe_n));
  gdp_pin_model u_gdp_pin_model (.pinOut(pinOut), .pinOe_n(pinOe_n),
    .boardLevel(boardLevel), .pinIn(pinIn));

  initial
  begin
    clk = 1'h0;
    forever #4 clk = ~clk;
  end

  // ----------------------------------------------------------------------
  // register port tasks
  // ----------------------------------------------------------------------
  task automatic wr(input gdp_addr_t a, input gdp_data_t d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'h1;
    @(posedge clk);
    wrStb  <= 1'h0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input gdp_addr_t a, output gdp_data_t d);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'h1;
    @(posedge clk);
    rdStb <= 1'h0;
    #1 d = rdData;
  endtask

  // four edges cover the driver flop and the two-flop pin synchroniser
  task automatic settle();
    repeat (4) @(posedge clk);
    #1;
  endtask

  task automatic end_of_test();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_of_test();
  end

  // ----------------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------------
  initial
  begin
    rst_n = 1'h0; addr = 8'h00; wrData = 16'h0000; wrStb = 1'h0; rdStb = 1'h0;
    boardLevel = 12'ha5a; n_errors = 0; checked = 0;
    repeat (8) @(posedge clk);
    rst_n <= 1'h1;
    settle();
    `CHK("reset oe", 12'hfff, pinOe_n)
    `CHK("reset out", 12'h000, pinOut)
    // level written while every pin is an input: stored, never driven
    wr(`GDP_ADDR_LEVEL, 16'h0fff);
    settle();
    `CHK("input out", 12'h000, pinOut)
    `CHK("input oe", 12'hfff, pinOe_n)
    rd(`GDP_ADDR_DIR, got);
    `CHK("reset dir", 16'h0000, got)
    rd(`GDP_ADDR_LEVEL, got);
    `CHK("input level", 16'h0a5a, got)
    // one pin at a time: bit n steers pin n only
    for (int n = 0; n < 12; n++)
    begin
      wr(`GDP_ADDR_DIR, 16'h0001 << n);
      wr(`GDP_ADDR_LEVEL, 16'hffff);
      settle();
      `CHK("walk oe", ~(12'h001 << n), pinOe_n)
      `CHK("walk out", 12'h001 << n, pinOut)
    end
    // stored level differs from the wire on input pins
    wr(`GDP_ADDR_DIR, 16'hf0f0);
    wr(`GDP_ADDR_LEVEL, 16'h00ff);
    settle();
    `CHK("mixed out", 12'h0f0, pinOut)
    rd(`GDP_ADDR_DIR, got);
    `CHK("dir back", 16'h00f0, got)
    rd(`GDP_ADDR_LEVEL, got);
    `CHK("mixed level", 16'h0afa, got)
    boardLevel <= 12'h5a5;
    settle();
    rd(`GDP_ADDR_LEVEL, got);
    `CHK("board level", 16'h05f5, got)
    // unmapped place: write ignored, read zero
    wr(8'h2c, 16'hffff);
    rd(8'h2c, got);
    `CHK("unmapped", 16'h0000, got)
    rd(`GDP_ADDR_DIR, got);
    `CHK("dir kept", 16'h00f0, got)
    // all outputs: the stored bits of former inputs now reach the pins
    wr(`GDP_ADDR_DIR, 16'h0fff);
    settle();
    `CHK("all out", 12'h0ff, pinOut)
    `CHK("all oe", 12'h000, pinOe_n)
    // all inputs again: nothing driven, wire follows the board
    wr(`GDP_ADDR_DIR, 16'h0000);
    settle();
    `CHK("off out", 12'h000, pinOut)
    `CHK("off oe", 12'hfff, pinOe_n)
    rd(`GDP_ADDR_LEVEL, got);
    `CHK("off level", 16'h05a5, got)
    end_of_test();
  end
endmodule

`default_nettype wire
